//--- hw/ptv_pkg.sv
// constants for the four-channel trip voting block: register map, field positions,
// reset values and trip-point defaults.
// assumes a 32-bit apb master and one 25 mhz clock.
package ptv_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_OVERPOWER = 8'h08;
    localparam logic [7:0] REG_TEMP_MAX = 8'h0c;
    localparam logic [7:0] REG_PRESS_MIN = 8'h10;
    localparam logic [7:0] REG_PRESS_MAX = 8'h14;
    localparam logic [7:0] REG_LOWP_BASE = 8'h18;
    localparam logic [7:0] REG_LOWP_SLOPE = 8'h1c;
    localparam logic [7:0] REG_BLDG_MAX = 8'h20;
    localparam logic [7:0] REG_IMB_GAIN = 8'h24;
    localparam logic [7:0] REG_PUMP_LIM = 8'h28;
    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int CTRL_BYP_LSB = 0;
    localparam int CTRL_BYP_EN = 2;
    localparam int CTRL_SD_BYP = 3;
    localparam int CTRL_MAN_TRIP = 4;
    localparam int NCH = 4;
    localparam int NPUMP = 4;
    localparam int DW = 16;
    // ------------------------------------------------------------
    // reset values of the trip points (plain defaults, full scale 16'hffff)
    // ------------------------------------------------------------
    localparam logic [15:0] RST_OVERPOWER = 16'hc000;
    localparam logic [15:0] RST_TEMP_MAX = 16'hc000;
    localparam logic [15:0] RST_PRESS_MIN = 16'h4000;
    localparam logic [15:0] RST_PRESS_MAX = 16'he000;
    localparam logic [15:0] RST_LOWP_BASE = 16'h2000;
    localparam logic [15:0] RST_LOWP_SLOPE = 16'h0100;
    localparam logic [15:0] RST_BLDG_MAX = 16'h8000;
    localparam logic [15:0] RST_IMB_GAIN = 16'h0100;
    // pump limit bytes: [31:24] three pumps, [23:16] two in both loops, [7:0] two in one loop or fewer
    localparam logic [31:0] RST_PUMP_LIM = 32'hb07f_0040;
    // flow gain 1.08 in 8.8 fixed point (276/256 = 1.078, truncation trips early)
    localparam logic [15:0] FLOW_GAIN_Q8 = 16'h0114;
endpackage

//--- hw/ptv_trip_vote.sv
// four-channel protective trip logic: per-channel or of trip conditions,
// four 2-of-4 vote modules, breaker drive and an apb register file.
// assumes measurements arrive as 16-bit unsigned words sampled on pclk; the
// discrete inputs come from pins and pass two flip-flops.
//
// Summary of operation
// - channel power loss trips the channel
// - removed module trips channel until restored
// - one channel at most held untripped
// - relay energized only while all normal or held
// - each channel trip fans to four modules
// - module trips on two of four
// - module A drives breaker A, etc
// - breakers A,C and B,D in series paths
// - power removed for AB, AD, BC, CD
// - undervoltage hold gated by manual trip
// - shunt trip energized on vote trip
// - trip when flux above overpower point
// - setpoint is flow times 1.08 minus imbalance
// - trip when flux exceeds flow setpoint
// - count running pumps, select power limit
// - trip when outlet temperature above limit
// - trip below temperature-dependent low pressure
// - trip outside fixed pressure band
// - trip when building pressure above maximum
// - anticipatory trip on feedwater or turbine
// - report trip, supply fail, bypass status
`timescale 1ns/100ps
module ptv_trip_vote (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [63:0] flux,
    input wire logic [63:0] flow,
    input wire logic [63:0] imbalance,
    input wire logic [63:0] outlet_temp,
    input wire logic [63:0] coolant_press,
    input wire logic [63:0] bldg_press,
    input wire logic [3:0] power_ok,
    input wire logic [3:0] modules_seated,
    input wire logic [3:0] det_supply_ok,
    input wire logic [15:0] pump_running,
    input wire logic [3:0] fw_pumps_lost,
    input wire logic [3:0] turbine_trip,
    input wire logic manual_trip_n,
    output logic [3:0] chan_trip,
    output logic [3:0] module_trip,
    output logic [3:0] undervoltage_hold,
    output logic [3:0] shunt_trip,
    output logic rod_power_on,
    output logic [3:0] det_supply_fail,
    output logic shutdown_bypass,
    output logic [3:0] chan_bypass
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NDISC = 37;
    logic [NDISC-1:0] disc_meta;
    logic [NDISC-1:0] disc_sync;
    logic [3:0] pwr_s;
    logic [3:0] seat_s;
    logic [3:0] det_s;
    logic [15:0] pump_s;
    logic [3:0] fw_s;
    logic [3:0] turb_s;
    logic man_s;

    // reset to zero: power, seating, supply, pump and manual inputs look tripped, feedwater and turbine inputs look healthy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disc_meta <= '0;
            disc_sync <= '0;
        end else begin
            disc_meta <= {manual_trip_n, turbine_trip, fw_pumps_lost, pump_running,
                          det_supply_ok, modules_seated, power_ok};
            disc_sync <= disc_meta;
        end
    end

    // only the second stage feeds logic
    assign pwr_s = disc_sync[3:0];
    assign seat_s = disc_sync[7:4];
    assign det_s = disc_sync[11:8];
    assign pump_s = disc_sync[27:12];
    assign fw_s = disc_sync[31:28];
    assign turb_s = disc_sync[35:32];
    assign man_s = disc_sync[36];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] byp_sel;
    logic byp_en;
    logic sd_byp;
    logic sw_man_trip;
    logic [15:0] op_lim;
    logic [15:0] temp_lim;
    logic [15:0] pmin_lim;
    logic [15:0] pmax_lim;
    logic [15:0] lowp_base;
    logic [15:0] lowp_slope;
    logic [15:0] bldg_lim;
    logic [15:0] imb_gain;
    logic [31:0] pump_lim;
    logic wr_en;

    // zero wait states: every access ends in one cycle
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;

    // new limits apply from the edge after the access
    // writable trip points
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byp_sel <= 2'h0;
            byp_en <= 1'b0;
            sd_byp <= 1'b0;
            sw_man_trip <= 1'b0;
            op_lim <= ptv_pkg::RST_OVERPOWER;
            temp_lim <= ptv_pkg::RST_TEMP_MAX;
            pmin_lim <= ptv_pkg::RST_PRESS_MIN;
            pmax_lim <= ptv_pkg::RST_PRESS_MAX;
            lowp_base <= ptv_pkg::RST_LOWP_BASE;
            lowp_slope <= ptv_pkg::RST_LOWP_SLOPE;
            bldg_lim <= ptv_pkg::RST_BLDG_MAX;
            imb_gain <= ptv_pkg::RST_IMB_GAIN;
            pump_lim <= ptv_pkg::RST_PUMP_LIM;
        end else if (wr_en) begin
            case (paddr)
                ptv_pkg::REG_CTRL: begin
                    byp_sel <= pwdata[ptv_pkg::CTRL_BYP_LSB +: 2];
                    byp_en <= pwdata[ptv_pkg::CTRL_BYP_EN];
                    sd_byp <= pwdata[ptv_pkg::CTRL_SD_BYP];
                    sw_man_trip <= pwdata[ptv_pkg::CTRL_MAN_TRIP];
                end
                ptv_pkg::REG_OVERPOWER: op_lim <= pwdata[15:0];
                ptv_pkg::REG_TEMP_MAX: temp_lim <= pwdata[15:0];
                ptv_pkg::REG_PRESS_MIN: pmin_lim <= pwdata[15:0];
                ptv_pkg::REG_PRESS_MAX: pmax_lim <= pwdata[15:0];
                ptv_pkg::REG_LOWP_BASE: lowp_base <= pwdata[15:0];
                ptv_pkg::REG_LOWP_SLOPE: lowp_slope <= pwdata[15:0];
                ptv_pkg::REG_BLDG_MAX: bldg_lim <= pwdata[15:0];
                ptv_pkg::REG_IMB_GAIN: imb_gain <= pwdata[15:0];
                ptv_pkg::REG_PUMP_LIM: pump_lim <= pwdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pump monitor
    // ------------------------------------------------------------
    logic [2:0] pump_cnt;
    logic [11:0] chan_pump_cnt;
    logic [63:0] chan_pump_limit;

    // status reports the count seen by channel A
    assign pump_cnt = chan_pump_cnt[2:0];

    generate
        for (genvar c = 0; c < ptv_pkg::NCH; c++) begin : g_pump
            logic [3:0] run;
            logic [2:0] cnt;
            logic [15:0] lim;

            // each channel reads its own contacts, so one bad copy stays local
            assign run = pump_s[c*4 +: 4];

            // running pump count and loop check
            always_comb begin
                cnt = 3'h0;
                for (int p = 0; p < ptv_pkg::NPUMP; p++) begin
                    cnt = cnt + 3'(run[p]);
                end
                case (cnt)
                    3'h4: lim = 16'hffff;
                    3'h3: lim = {pump_lim[31:24], 8'h00};
                    3'h2: begin
                        // pumps 0,1 form loop a and 2,3 loop b; both in one loop is worse
                        if ((run[1:0] == 2'h3) || (run[3:2] == 2'h3)) begin
                            lim = {pump_lim[7:0], 8'h00};
                        end else begin
                            lim = {pump_lim[23:16], 8'h00};
                        end
                    end
                    default: lim = {pump_lim[7:0], 8'h00};
                endcase
            end

            assign chan_pump_cnt[c*3 +: 3] = cnt;
            assign chan_pump_limit[c*16 +: 16] = lim;
        end
    endgenerate

    // ------------------------------------------------------------
    // per-channel trip conditions
    // ------------------------------------------------------------
    logic [3:0] next_chan_trip;
    logic [3:0] held;

    // shutdown bypass lifts the maintenance hold
    // at most one channel held untripped
    assign held = (byp_en && !sd_byp) ? (4'h1 << byp_sel) : 4'h0;

    generate
        for (genvar c = 0; c < ptv_pkg::NCH; c++) begin : g_chan
            logic [15:0] fx;
            logic [15:0] fl;
            logic [15:0] im;
            logic [15:0] tp;
            logic [15:0] pr;
            logic [15:0] bp;
            logic [31:0] flow_sp_raw;
            logic [31:0] imb_red;
            logic [31:0] flow_sp;
            logic [31:0] lowp_raw;
            logic [15:0] lowp_sp;
            logic abnormal;

            assign fx = flux[c*16 +: 16];
            assign fl = flow[c*16 +: 16];
            assign im = imbalance[c*16 +: 16];
            assign tp = outlet_temp[c*16 +: 16];
            assign pr = coolant_press[c*16 +: 16];
            assign bp = bldg_press[c*16 +: 16];

            // flow times 1.08 less imbalance term
            assign flow_sp_raw = (32'(fl) * 32'(ptv_pkg::FLOW_GAIN_Q8)) >> 8;
            assign imb_red = (32'(im) * 32'(imb_gain)) >> 8;
            assign flow_sp = (flow_sp_raw > imb_red) ? flow_sp_raw - imb_red : 32'h0;

            // low pressure limit rises with temperature
            assign lowp_raw = 32'(lowp_base) + ((32'(tp) * 32'(lowp_slope)) >> 8);
            assign lowp_sp = (lowp_raw > 32'h0000ffff) ? 16'hffff : lowp_raw[15:0];

            // any abnormal input deenergizes the relay; a held channel ignores all but power loss and removal
            always_comb begin
                abnormal = 1'b0;
                if (!pwr_s[c]) abnormal = 1'b1;
                if (!seat_s[c]) abnormal = 1'b1;
                if (fx > op_lim) abnormal = 1'b1;
                if (32'(fx) > flow_sp) abnormal = 1'b1;
                if (fx > chan_pump_limit[c*16 +: 16]) abnormal = 1'b1;
                if (tp > temp_lim) abnormal = 1'b1;
                if (pr < lowp_sp) abnormal = 1'b1;
                if (pr < pmin_lim || pr > pmax_lim) abnormal = 1'b1;
                if (bp > bldg_lim) abnormal = 1'b1;
                if (fw_s[c] || turb_s[c]) abnormal = 1'b1;
            end

            // power loss and removal override the maintenance hold: fail safe
            assign next_chan_trip[c] = !pwr_s[c] || !seat_s[c] || (abnormal && !held[c]);
        end
    endgenerate

    // reset leaves every relay deenergized
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_trip <= 4'hf;
        end else begin
            chan_trip <= next_chan_trip;
        end
    end

    // ------------------------------------------------------------
    // vote modules and breakers
    // ------------------------------------------------------------
    logic [3:0] next_module_trip;
    logic man_trip;

    // manual trip drops holds only, not the vote
    assign man_trip = !man_s || sw_man_trip;

    generate
        for (genvar m = 0; m < ptv_pkg::NCH; m++) begin : g_vote
            logic [2:0] votes;
            // every module sees all four channels
            assign votes = 3'(chan_trip[0]) + 3'(chan_trip[1])
                         + 3'(chan_trip[2]) + 3'(chan_trip[3]);
            assign next_module_trip[m] = (votes >= 3'h2);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_trip <= 4'hf;
            undervoltage_hold <= 4'h0;
            shunt_trip <= 4'h0;
        end else begin
            module_trip <= next_module_trip;
            // hold per breaker, manual switch in series
            undervoltage_hold <= ~next_module_trip & {4{!man_trip}} & pwr_s;
            shunt_trip <= next_module_trip;
        end
    end

    // no register here, so rod power tracks the holds
    // paths A-C and B-D; index 0..3 is A..D
    assign rod_power_on = (undervoltage_hold[0] && undervoltage_hold[2])
                       || (undervoltage_hold[1] && undervoltage_hold[3]);

    // ------------------------------------------------------------
    // status and read back
    // ------------------------------------------------------------
    // separate indications
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_supply_fail <= 4'h0;
            shutdown_bypass <= 1'b0;
            chan_bypass <= 4'h0;
        end else begin
            det_supply_fail <= ~det_s;
            shutdown_bypass <= sd_byp;
            chan_bypass <= held;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable && !pwrite) begin
            // launched at setup so it stands in the access phase
            pslverr <= 1'b0;
            case (paddr)
                ptv_pkg::REG_CTRL: prdata <= {27'h0, sw_man_trip, sd_byp, byp_en, byp_sel};
                ptv_pkg::REG_STATUS: prdata <= {11'h0, pump_cnt, shutdown_bypass,
                                                rod_power_on, chan_bypass, det_supply_fail,
                                                module_trip, chan_trip};
                ptv_pkg::REG_OVERPOWER: prdata <= {16'h0, op_lim};
                ptv_pkg::REG_TEMP_MAX: prdata <= {16'h0, temp_lim};
                ptv_pkg::REG_PRESS_MIN: prdata <= {16'h0, pmin_lim};
                ptv_pkg::REG_PRESS_MAX: prdata <= {16'h0, pmax_lim};
                ptv_pkg::REG_LOWP_BASE: prdata <= {16'h0, lowp_base};
                ptv_pkg::REG_LOWP_SLOPE: prdata <= {16'h0, lowp_slope};
                ptv_pkg::REG_BLDG_MAX: prdata <= {16'h0, bldg_lim};
                ptv_pkg::REG_IMB_GAIN: prdata <= {16'h0, imb_gain};
                ptv_pkg::REG_PUMP_LIM: prdata <= pump_lim;
                default: begin
                    prdata <= 32'h0;
                    pslverr <= 1'b1;
                end
            endcase
        end else if (psel && !penable && pwrite) begin
            // writes to status or a hole are flagged and dropped
            prdata <= 32'h0;
            pslverr <= !(paddr == ptv_pkg::REG_CTRL || (paddr >= ptv_pkg::REG_OVERPOWER
                         && paddr <= ptv_pkg::REG_PUMP_LIM && paddr[1:0] == 2'h0));
        end
    end
endmodule

//--- tb/ptv_plant_model.sv
// plant side: sensor words for each channel and the rod drive breakers.
// assumes the bench picks the abnormal channels and the kind of fault.
`timescale 1ns/100ps
module ptv_plant_model (
    input wire logic [3:0] abn,
    input wire logic [3:0] kind,
    input wire logic [3:0] undervoltage_hold,
    input wire logic [3:0] shunt_trip,
    output logic [63:0] flux,
    output logic [63:0] flow,
    output logic [63:0] imbalance,
    output logic [63:0] outlet_temp,
    output logic [63:0] coolant_press,
    output logic [63:0] bldg_press,
    output logic [15:0] pump_running,
    output logic [3:0] fw_pumps_lost,
    output logic [3:0] turbine_trip,
    output logic rod_power_ok
);
    logic [3:0] closed;
    // pumps are plant-wide, so in kind 9 every channel sees the same single pump
    always_comb begin
        pump_running = (kind == 4'h9 && abn != 4'h0) ? 16'h1111 : 16'hffff;
        fw_pumps_lost = 4'h0;
        turbine_trip = 4'h0;
        for (int c = 0; c < 4; c++) begin
            flux[c*16 +: 16] = 16'h4000;
            flow[c*16 +: 16] = 16'hffff;
            imbalance[c*16 +: 16] = 16'h0000;
            outlet_temp[c*16 +: 16] = 16'h4000;
            coolant_press[c*16 +: 16] = 16'h8000;
            bldg_press[c*16 +: 16] = 16'h1000;
            if (abn[c]) begin
                case (kind)
                    4'h0: flux[c*16 +: 16] = 16'hd000;
                    4'h1: flow[c*16 +: 16] = 16'h0000;
                    4'h2: outlet_temp[c*16 +: 16] = 16'hd000;
                    4'h3: coolant_press[c*16 +: 16] = 16'h1000;
                    4'h4: coolant_press[c*16 +: 16] = 16'hf000;
                    4'h5: bldg_press[c*16 +: 16] = 16'h9000;
                    4'h6: fw_pumps_lost[c] = 1'b1;
                    4'h7: turbine_trip[c] = 1'b1;
                    4'h8: outlet_temp[c*16 +: 16] = 16'h7000;
                    4'h9: flux[c*16 +: 16] = 16'hb800;
                    default: begin
                        flow[c*16 +: 16] = 16'h4000;
                        flux[c*16 +: 16] = (kind == 4'hb) ? 16'h4600 : 16'h4400;
                        imbalance[c*16 +: 16] = (kind == 4'hc) ? 16'h0200 : 16'h0000;
                    end
                endcase
            end
        end
    end
    assign closed = undervoltage_hold & ~shunt_trip;
    assign rod_power_ok = (closed[0] & closed[2]) | (closed[1] & closed[3]);
endmodule

//--- tb/ptv_trip_vote_properties.sv
// checker for the trip voting block: vote, breaker, manual trip and loss relations.
// assumes it is bound to ptv_trip_vote and sees only that module's ports.
`timescale 1ns/100ps
module ptv_trip_vote_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] power_ok,
    input wire logic [3:0] modules_seated,
    input wire logic manual_trip_n,
    input wire logic [3:0] chan_trip,
    input wire logic [3:0] module_trip,
    input wire logic [3:0] undervoltage_hold,
    input wire logic [3:0] shunt_trip,
    input wire logic rod_power_on,
    input wire logic [3:0] chan_bypass
);
    logic [3:0] lost1;
    logic [3:0] lost2;
    logic [3:0] lost3;
    logic up;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // three samples in loss cover the two-stage synchroniser plus the trip register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost1 <= 4'h0;
            lost2 <= 4'h0;
            lost3 <= 4'h0;
        end else begin
            lost1 <= ~power_ok | ~modules_seated;
            lost2 <= lost1 & (~power_ok | ~modules_seated);
            lost3 <= lost2 & (~power_ok | ~modules_seated);
        end
    end
    // outputs leave their reset values at the first edge, so wait one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up <= 1'b0;
        end else begin
            up <= 1'b1;
        end
    end
    sequence two_tripped_s;
        $countones(chan_trip) >= 2;
    endsequence
    sequence manual_low_s;
        !manual_trip_n [*4];
    endsequence
    vote_trips_all_a: assert property (
        two_tripped_s |=> module_trip == 4'hf) else $error("vote missed");
    vote_quiet_a: assert property (
        $countones(chan_trip) < 2 |=> module_trip == 4'h0) else $error("vote spurious");
    shunt_follow_a: assert property (
        up |-> shunt_trip == module_trip) else $error("shunt differs from vote");
    hold_gated_a: assert property (
        (undervoltage_hold & module_trip) == 4'h0) else $error("hold kept on vote trip");
    manual_drop_a: assert property (
        manual_low_s |=> undervoltage_hold == 4'h0) else $error("manual trip ignored");
    loss_trips_a: assert property (
        (chan_trip & lost3) == lost3) else $error("loss did not trip");
    rod_paths_a: assert property (
        rod_power_on == ((undervoltage_hold[0] & undervoltage_hold[2])
        | (undervoltage_hold[1] & undervoltage_hold[3]))) else $error("rod power wrong");
    one_bypass_a: assert property (
        $countones(chan_bypass) <= 1) else $error("two channels held");
endmodule

bind ptv_trip_vote ptv_trip_vote_properties u_props (
    .pclk, .presetn, .power_ok, .modules_seated, .manual_trip_n, .chan_trip,
    .module_trip, .undervoltage_hold, .shunt_trip, .rod_power_on, .chan_bypass
);

//--- tb/tb.sv
// self-checking bench for the trip voting block with a plant model.
// assumes the apb slave answers with pready high and outputs settle in four edges.
`timescale 1ns/100ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic manual_trip_n = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] power_ok = 4'hf;
    logic [3:0] modules_seated = 4'hf;
    logic [3:0] det_supply_ok = 4'hf;
    logic [3:0] abn = 4'h0;
    logic [3:0] kind = 4'h0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, rod_power_on, shutdown_bypass, rod_ok;
    logic [63:0] flux, flow, imbalance, outlet_temp, coolant_press, bldg_press;
    logic [15:0] pump_running;
    logic [3:0] fw_pumps_lost, turbine_trip, chan_trip, module_trip;
    logic [3:0] undervoltage_hold, shunt_trip, det_supply_fail, chan_bypass;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    ptv_trip_vote dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .flux, .flow, .imbalance, .outlet_temp,
        .coolant_press, .bldg_press, .power_ok, .modules_seated, .det_supply_ok,
        .pump_running, .fw_pumps_lost, .turbine_trip, .manual_trip_n, .chan_trip,
        .module_trip, .undervoltage_hold, .shunt_trip, .rod_power_on,
        .det_supply_fail, .shutdown_bypass, .chan_bypass);
    ptv_plant_model partner (.abn, .kind, .undervoltage_hold, .shunt_trip, .flux,
        .flow, .imbalance, .outlet_temp, .coolant_press, .bldg_press, .pump_running,
        .fw_pumps_lost, .turbine_trip, .rod_power_ok(rod_ok));
    always #20 pclk = ~pclk;
    task automatic end_sim();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic outs(input logic [3:0] ct, input logic [3:0] mt, input logic [3:0] hold,
        input logic rp);
        chk(chan_trip, ct);
        chk(module_trip, mt);
        chk(shunt_trip, mt);
        chk(undervoltage_hold, hold);
        chk(rod_power_on, rp);
        chk(rod_ok, rp);
    endtask
    // one idle cycle closes each transfer so back-to-back calls never collide
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic step();
        repeat (6) @(posedge pclk);
    endtask
    task automatic t_regs();
        logic [31:0] v [11] = '{32'h0, 32'h0011_0000, 32'(ptv_pkg::RST_OVERPOWER),
            32'(ptv_pkg::RST_TEMP_MAX), 32'(ptv_pkg::RST_PRESS_MIN),
            32'(ptv_pkg::RST_PRESS_MAX), 32'(ptv_pkg::RST_LOWP_BASE),
            32'(ptv_pkg::RST_LOWP_SLOPE), 32'(ptv_pkg::RST_BLDG_MAX),
            32'(ptv_pkg::RST_IMB_GAIN), ptv_pkg::RST_PUMP_LIM};
        for (int i = 0; i < 11; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rdata, v[i]);
        end
        apb(1'b0, 8'h2c, 32'h0);
        chk(rdata, 32'h0);
        chk(rerr, 1'b1);
        chk(pready, 1'b1);
        apb(1'b1, ptv_pkg::REG_STATUS, 32'hffff_ffff);
        chk(rerr, 1'b1);
    endtask
    task automatic t_kinds();
        logic [3:0] one;
        logic [3:0] two;
        for (int k = 0; k < 10; k++) begin
            one = 4'h1 << (k % 4);
            two = one | (4'h1 << ((k + 1) % 4));
            kind <= 4'(k);
            abn <= one;
            step();
            outs(one, 4'h0, 4'hf, 1'b1);
            abn <= two;
            step();
            outs(two, 4'hf, 4'h0, 1'b0);
            abn <= 4'h0;
            step();
        end
    endtask
    task automatic t_flow();
        logic [3:0] e [3] = '{4'h0, 4'h1, 4'h1};
        for (int k = 0; k < 3; k++) begin
            kind <= 4'(k + 10);
            abn <= 4'h1;
            step();
            chk(chan_trip, e[k]);
        end
        abn <= 4'h0;
        kind <= 4'h0;
        step();
    endtask
    task automatic t_loss();
        power_ok <= 4'hb;
        step();
        outs(4'h4, 4'h0, 4'hb, 1'b1);
        power_ok <= 4'hf;
        modules_seated <= 4'h7;
        step();
        outs(4'h8, 4'h0, 4'hf, 1'b1);
        modules_seated <= 4'hf;
        det_supply_ok <= 4'hd;
        step();
        chk(chan_trip, 4'h0);
        chk(det_supply_fail, 4'h2);
        det_supply_ok <= 4'hf;
    endtask
    task automatic t_bypass();
        apb(1'b1, ptv_pkg::REG_CTRL, 32'h5);
        abn <= 4'h2;
        step();
        chk(chan_bypass, 4'h2);
        chk(chan_trip, 4'h0);
        abn <= 4'h6;
        step();
        outs(4'h4, 4'h0, 4'hf, 1'b1);
        apb(1'b1, ptv_pkg::REG_CTRL, 32'h6);
        step();
        chk(chan_bypass, 4'h4);
        chk(chan_trip, 4'h2);
        power_ok <= 4'hb;
        step();
        outs(4'h6, 4'hf, 4'h0, 1'b0);
        power_ok <= 4'hf;
        apb(1'b1, ptv_pkg::REG_CTRL, 32'he);
        step();
        chk(chan_trip, 4'h6);
        chk(shutdown_bypass, 1'b1);
        apb(1'b1, ptv_pkg::REG_CTRL, 32'h0);
        abn <= 4'h0;
        step();
    endtask
    task automatic t_manual();
        manual_trip_n <= 1'b0;
        step();
        outs(4'h0, 4'h0, 4'h0, 1'b0);
        manual_trip_n <= 1'b1;
        apb(1'b1, ptv_pkg::REG_CTRL, 32'h10);
        step();
        outs(4'h0, 4'h0, 4'h0, 1'b0);
        apb(1'b1, ptv_pkg::REG_CTRL, 32'h0);
        step();
        outs(4'h0, 4'h0, 4'hf, 1'b1);
    endtask
    task automatic t_limit();
        apb(1'b1, ptv_pkg::REG_OVERPOWER, 32'h3000);
        apb(1'b0, ptv_pkg::REG_OVERPOWER, 32'h0);
        chk(rdata, 32'h3000);
        step();
        outs(4'hf, 4'hf, 4'h0, 1'b0);
        apb(1'b1, ptv_pkg::REG_OVERPOWER, 32'(ptv_pkg::RST_OVERPOWER));
        step();
        chk(chan_trip, 4'h0);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        step();
        t_regs();
        t_kinds();
        t_flow();
        t_loss();
        t_bypass();
        t_manual();
        t_limit();
        end_sim();
    end
endmodule
